// *** design/reset_timeout_and_cause_logic.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Power-on starts enabled power-up delay, core held
// - Crystal modes count 1024 oscillator cycles after delay
// - Pin held low past delays: run at release
// - Crystal: delay plus count; delay alone otherwise
// - Brown-out flag bit 0, cleared on brown-out
// - Brown-out flag undefined while detector disabled
// - Power-on flag bit 1, cleared by power-on or a software write
// - Power-on: both flags set, PC zero, banks cleared
// - Power-on flag stays low through sleep until software sets it
// - Pin reset running: PC zero, banks cleared only
// - Pin reset asleep: PC zero, expired set, sleep cleared
// - Interrupt wake: next address, expired set, sleep cleared
// - Wake with interrupts enabled loads interrupt vector
// - Unimplemented bits read as zero
// - Brown-out holds reset, then always runs delay
// - Oscillator count only crystal, power-on, brown-out or wake
// - Watchdog reset never drives reset pin low
module reset_timeout_and_cause_logic #(
   parameter int unsigned POWER_UP_DELAY_CYCLES = reset_timeout_pkg::POWER_UP_DELAY_CYC,
   parameter int unsigned OSC_STARTUP_CYCLES    = reset_timeout_pkg::OSC_STARTUP_PERIODS
) (
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   // Register bus
   input  wire reset_timeout_pkg::apb_req_s apb_req_i,
   output      reset_timeout_pkg::apb_rsp_s apb_rsp_o,
   // Supply detectors, pin and oscillator
   input  wire logic                        power_on_detect_i,
   input  wire logic                        supply_low_i,
   input  wire logic                        external_reset_n_i,
   input  wire logic                        osc_clk_i,
   // Core events
   input  wire logic                        watchdog_timeout_i,
   input  wire logic                        wake_irq_i,
   input  wire logic                        global_irq_enable_i,
   input  wire logic                        sleep_cmd_i,
   input  wire logic                        watchdog_clear_cmd_i,
   input  wire logic [12:0]                 pc_current_i,
   // Core control
   output      logic                        core_reset_o,
   output      logic                        core_run_o,
   output      logic                        pc_load_o,
   output      logic [12:0]                 pc_target_o,
   output      logic                        bank_clear_o,
   output      logic                        watchdog_expired_n_o,
   output      logic                        sleep_entered_n_o
);

   //////////////////////////////////////////////////////////////////////////////
   localparam logic [reset_timeout_pkg::DELAY_CNT_W-1:0] DELAY_LAST =
      reset_timeout_pkg::DELAY_CNT_W'(POWER_UP_DELAY_CYCLES - 1);
   localparam logic [reset_timeout_pkg::OSC_CNT_W-1:0] OSC_LAST =
      reset_timeout_pkg::OSC_CNT_W'(OSC_STARTUP_CYCLES - 1);

   reset_timeout_pkg::seq_regs_s r;
   reset_timeout_pkg::seq_regs_s next_r;

   logic crystal;
   logic delay_wanted;
   logic brownout_active;
   logic pin_fall;
   logic osc_edge;
   logic setup;
   logic access;
   logic wr;
   logic mapped;

   //////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      crystal         = (r.osc_mode != reset_timeout_pkg::OSC_RESISTOR_CAPACITOR);
      delay_wanted    = ~r.power_up_delay_off | r.brownout_enable;
      brownout_active = r.brownout_enable & supply_low_i;
      pin_fall        = r.pin_prev & ~external_reset_n_i;
      osc_edge        = osc_clk_i & ~r.osc_prev;
      setup           = apb_req_i.psel & ~apb_req_i.penable;
      access          = apb_req_i.psel & apb_req_i.penable;
      wr              = access & apb_req_i.pwrite;
      mapped          = (apb_req_i.paddr == reset_timeout_pkg::ADDR_POWER_RESET_CAUSE) |
                        (apb_req_i.paddr == reset_timeout_pkg::ADDR_RESET_STATUS) |
                        (apb_req_i.paddr == reset_timeout_pkg::ADDR_CONFIG);
   end

   //////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_r            = r;
      next_r.pc_load    = 1'b0;
      next_r.bank_clear = 1'b0;
      next_r.osc_prev   = osc_clk_i;
      next_r.pin_prev   = external_reset_n_i;

      // Software writes first so that any hardware event below wins the cycle
      if (wr && apb_req_i.paddr == reset_timeout_pkg::ADDR_POWER_RESET_CAUSE)
      begin
         next_r.brownout_flag_n = apb_req_i.pwdata[reset_timeout_pkg::BIT_BROWNOUT_FLAG];
         next_r.power_on_flag_n = apb_req_i.pwdata[reset_timeout_pkg::BIT_POWER_ON_FLAG];
      end
      if (wr && apb_req_i.paddr == reset_timeout_pkg::ADDR_CONFIG)
      begin
         next_r.osc_mode           = apb_req_i.pwdata[reset_timeout_pkg::CFG_MODE_LSB +: 2];
         next_r.power_up_delay_off = apb_req_i.pwdata[reset_timeout_pkg::BIT_DELAY_OFF];
         next_r.brownout_enable    = apb_req_i.pwdata[reset_timeout_pkg::BIT_BROWNOUT_EN];
      end

      // Instruction side effects on the cause flags
      if (sleep_cmd_i && r.state == reset_timeout_pkg::ST_RUN)
      begin
         next_r.sleeping           = 1'b1;
         next_r.watchdog_expired_n = 1'b1;
         next_r.sleep_entered_n    = 1'b0;
      end
      else if (watchdog_clear_cmd_i)
      begin
         next_r.watchdog_expired_n = 1'b1;
         next_r.sleep_entered_n    = 1'b1;
      end

      // Sequencer
      case (r.state)
         reset_timeout_pkg::ST_RUN:
         begin
            next_r.delay_cnt = '0;
            next_r.osc_cnt   = '0;
         end
         reset_timeout_pkg::ST_HOLD:
         begin
            // Each new rise above threshold restarts the delay from zero
            next_r.delay_cnt = '0;
            if (!brownout_active)
            begin
               next_r.state = reset_timeout_pkg::ST_DELAY;
            end
         end
         reset_timeout_pkg::ST_DELAY:
         begin
            if (r.delay_cnt == DELAY_LAST)
            begin
               next_r.delay_cnt = '0;
               next_r.osc_cnt   = '0;
               // RC mode ends here; crystal modes go on to count
               next_r.state     = crystal ? reset_timeout_pkg::ST_OSC : reset_timeout_pkg::ST_RUN;
            end
            else
            begin
               next_r.delay_cnt = r.delay_cnt + 1'b1;
            end
         end
         reset_timeout_pkg::ST_OSC:
         begin
            if (osc_edge)
            begin
               if (r.osc_cnt == OSC_LAST)
               begin
                  next_r.state = reset_timeout_pkg::ST_RUN;
               end
               else
               begin
                  next_r.osc_cnt = r.osc_cnt + 1'b1;
               end
            end
         end
         reset_timeout_pkg::ST_PULSE:
         begin
            next_r.state = reset_timeout_pkg::ST_RUN;
         end
         default:
         begin
            next_r.state = reset_timeout_pkg::ST_HOLD;
         end
      endcase

      // Reset and wake events, highest priority first
      if (power_on_detect_i)
      begin
         next_r.power_on_flag_n    = 1'b0;
         next_r.watchdog_expired_n = 1'b1;
         next_r.sleep_entered_n    = 1'b1;
         next_r.sleeping           = 1'b0;
         next_r.pc_load            = 1'b1;
         next_r.pc_target          = reset_timeout_pkg::PC_RESET_ADDR;
         next_r.bank_clear         = 1'b1;
         next_r.delay_cnt          = '0;
         next_r.osc_cnt            = '0;
         if (delay_wanted)
         begin
            next_r.state = reset_timeout_pkg::ST_DELAY;
         end
         else
         begin
            next_r.state = crystal ? reset_timeout_pkg::ST_OSC : reset_timeout_pkg::ST_RUN;
         end
      end
      else if (brownout_active)
      begin
         // Brown-out flag is left alone when the detector is off
         next_r.brownout_flag_n    = 1'b0;
         next_r.watchdog_expired_n = 1'b1;
         next_r.sleep_entered_n    = 1'b1;
         next_r.sleeping           = 1'b0;
         next_r.pc_load            = 1'b1;
         next_r.pc_target          = reset_timeout_pkg::PC_RESET_ADDR;
         next_r.bank_clear         = 1'b1;
         next_r.state              = reset_timeout_pkg::ST_HOLD;
      end
      else if (pin_fall && r.state != reset_timeout_pkg::ST_DELAY && r.state != reset_timeout_pkg::ST_OSC)
      begin
         next_r.pc_load    = 1'b1;
         next_r.pc_target  = reset_timeout_pkg::PC_RESET_ADDR;
         next_r.bank_clear = 1'b1;
         if (r.sleeping)
         begin
            next_r.watchdog_expired_n = 1'b1;
            next_r.sleep_entered_n    = 1'b0;
            next_r.sleeping           = 1'b0;
            next_r.state              = reset_timeout_pkg::ST_RUN;
         end
      end
      else if (watchdog_timeout_i && r.state == reset_timeout_pkg::ST_RUN)
      begin
         next_r.watchdog_expired_n = 1'b0;
         next_r.pc_load            = 1'b1;
         if (r.sleeping)
         begin
            next_r.sleep_entered_n = 1'b0;
            next_r.sleeping        = 1'b0;
            next_r.pc_target       = PC_W_NEXT(pc_current_i);
            next_r.state           = crystal ? reset_timeout_pkg::ST_OSC : reset_timeout_pkg::ST_RUN;
         end
         else
         begin
            // Internal pulse only; the reset pin has no output driver here
            next_r.sleep_entered_n = 1'b1;
            next_r.pc_target       = reset_timeout_pkg::PC_RESET_ADDR;
            next_r.bank_clear      = 1'b1;
            next_r.state           = reset_timeout_pkg::ST_PULSE;
         end
      end
      else if (wake_irq_i && r.sleeping && r.state == reset_timeout_pkg::ST_RUN)
      begin
         next_r.watchdog_expired_n = 1'b1;
         next_r.sleep_entered_n    = 1'b0;
         next_r.sleeping           = 1'b0;
         next_r.pc_load            = 1'b1;
         next_r.pc_target          = global_irq_enable_i ? reset_timeout_pkg::PC_IRQ_VECTOR
                                                         : PC_W_NEXT(pc_current_i);
         next_r.state              = crystal ? reset_timeout_pkg::ST_OSC : reset_timeout_pkg::ST_RUN;
      end

      // Read data is captured in the setup phase so it leaves a flop
      if (setup)
      begin
         next_r.prdata = '0;
         case (apb_req_i.paddr)
            reset_timeout_pkg::ADDR_POWER_RESET_CAUSE:
            begin
               next_r.prdata[reset_timeout_pkg::BIT_BROWNOUT_FLAG] = r.brownout_flag_n;
               next_r.prdata[reset_timeout_pkg::BIT_POWER_ON_FLAG] = r.power_on_flag_n;
            end
            reset_timeout_pkg::ADDR_RESET_STATUS:
            begin
               next_r.prdata[reset_timeout_pkg::BIT_WATCHDOG_EXP]  = r.watchdog_expired_n;
               next_r.prdata[reset_timeout_pkg::BIT_SLEEP_ENTERED] = r.sleep_entered_n;
               next_r.prdata[reset_timeout_pkg::BIT_CORE_RESET]    = core_reset_o;
               next_r.prdata[reset_timeout_pkg::BIT_SLEEPING]      = r.sleeping;
               next_r.prdata[reset_timeout_pkg::STATE_LSB +: 5]    = r.state;
            end
            reset_timeout_pkg::ADDR_CONFIG:
            begin
               next_r.prdata[reset_timeout_pkg::CFG_MODE_LSB +: 2]  = r.osc_mode;
               next_r.prdata[reset_timeout_pkg::BIT_DELAY_OFF]      = r.power_up_delay_off;
               next_r.prdata[reset_timeout_pkg::BIT_BROWNOUT_EN]    = r.brownout_enable;
            end
            default:
            begin
               next_r.prdata = '0;
            end
         endcase
      end
   end

   function automatic logic [reset_timeout_pkg::PC_W-1:0] PC_W_NEXT(input logic [12:0] pc);
      PC_W_NEXT = pc + 13'h0001;
   endfunction : PC_W_NEXT

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         r                    <= '0;
         r.state              <= reset_timeout_pkg::ST_HOLD;
         r.pin_prev           <= 1'b1;
         r.watchdog_expired_n <= 1'b1;
         r.sleep_entered_n    <= 1'b1;
         r.osc_mode           <= reset_timeout_pkg::CFG_MODE_RESET;
         r.power_up_delay_off <= reset_timeout_pkg::CFG_DELAY_OFF_RESET;
         r.brownout_enable    <= reset_timeout_pkg::CFG_BO_EN_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      // The pin term lets parts sharing one pin start together
      core_reset_o          = (r.state == reset_timeout_pkg::ST_HOLD) |
                              (r.state == reset_timeout_pkg::ST_DELAY) |
                              (r.state == reset_timeout_pkg::ST_PULSE) |
                              ((r.state == reset_timeout_pkg::ST_OSC) & ~r.sleeping & r.pc_target ==
                               reset_timeout_pkg::PC_RESET_ADDR) |
                              ~external_reset_n_i;
      core_run_o            = (r.state == reset_timeout_pkg::ST_RUN) & external_reset_n_i & ~r.sleeping;
      pc_load_o             = r.pc_load;
      pc_target_o           = r.pc_target;
      bank_clear_o          = r.bank_clear;
      watchdog_expired_n_o  = r.watchdog_expired_n;
      sleep_entered_n_o     = r.sleep_entered_n;
      apb_rsp_o.prdata      = r.prdata;
      apb_rsp_o.pready      = access;
      apb_rsp_o.pslverr     = access & ~mapped;
   end

endmodule : reset_timeout_and_cause_logic

// *** design/reset_timeout_pkg.sv ***
package reset_timeout_pkg;

   // Clock and delays
   localparam int unsigned CLK_MHZ              = 40;
   localparam int unsigned POWER_UP_DELAY_US    = 72000;
   localparam int unsigned POWER_UP_DELAY_CYC   = POWER_UP_DELAY_US * CLK_MHZ;
   localparam int unsigned OSC_STARTUP_PERIODS  = 1024;
   localparam int unsigned DELAY_CNT_W          = 22;
   localparam int unsigned OSC_CNT_W            = 11;

   // Program counter
   localparam int unsigned PC_W                 = 13;
   localparam logic [12:0] PC_RESET_ADDR        = 13'h0000;
   localparam logic [12:0] PC_IRQ_VECTOR        = 13'h0004;

   // Register map, byte addresses
   localparam logic [7:0]  ADDR_POWER_RESET_CAUSE = 8'h00;
   localparam logic [7:0]  ADDR_RESET_STATUS      = 8'h04;
   localparam logic [7:0]  ADDR_CONFIG            = 8'h08;

   // power_reset_cause fields
   localparam int unsigned BIT_BROWNOUT_FLAG    = 0;
   localparam int unsigned BIT_POWER_ON_FLAG    = 1;
   // reset_status fields
   localparam int unsigned BIT_WATCHDOG_EXP     = 0;
   localparam int unsigned BIT_SLEEP_ENTERED    = 1;
   localparam int unsigned BIT_CORE_RESET       = 2;
   localparam int unsigned BIT_SLEEPING         = 3;
   localparam int unsigned STATE_LSB            = 4;
   // config fields
   localparam int unsigned CFG_MODE_LSB         = 0;
   localparam int unsigned BIT_DELAY_OFF        = 2;
   localparam int unsigned BIT_BROWNOUT_EN      = 3;

   // Oscillator modes
   localparam logic [1:0]  OSC_LOW_POWER_CRYSTAL  = 2'h0;
   localparam logic [1:0]  OSC_CRYSTAL            = 2'h1;
   localparam logic [1:0]  OSC_HIGH_SPEED_CRYSTAL = 2'h2;
   localparam logic [1:0]  OSC_RESISTOR_CAPACITOR = 2'h3;

   // Reset values
   localparam logic [1:0]  CFG_MODE_RESET       = 2'h1;
   localparam logic        CFG_DELAY_OFF_RESET  = 1'b0;
   localparam logic        CFG_BO_EN_RESET      = 1'b1;

   typedef enum logic [4:0] {
      ST_RUN   = 5'h01,
      ST_HOLD  = 5'h02,
      ST_DELAY = 5'h04,
      ST_OSC   = 5'h08,
      ST_PULSE = 5'h10
   } seq_state_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   typedef struct packed {
      seq_state_e              state;
      logic [DELAY_CNT_W-1:0]  delay_cnt;
      logic [OSC_CNT_W-1:0]    osc_cnt;
      logic                    osc_prev;
      logic                    pin_prev;
      logic                    brownout_seen;
      logic                    sleeping;
      logic                    watchdog_expired_n;
      logic                    sleep_entered_n;
      logic                    brownout_flag_n;
      logic                    power_on_flag_n;
      logic [1:0]              osc_mode;
      logic                    power_up_delay_off;
      logic                    brownout_enable;
      logic                    pc_load;
      logic [PC_W-1:0]         pc_target;
      logic                    bank_clear;
      logic [31:0]             prdata;
   } seq_regs_s;

endpackage : reset_timeout_pkg

// *** testbench/reset_cause_checker.sv ***
`timescale 1ns/1ps
module reset_cause_checker (
   // Clock and reset
   input wire logic                        clk_i,
   input wire logic                        rst_n_i,
   // Register bus
   input wire reset_timeout_pkg::apb_req_s apb_req_i,
   input wire reset_timeout_pkg::apb_rsp_s apb_rsp_o,
   // Events
   input wire logic                        power_on_detect_i,
   input wire logic                        external_reset_n_i,
   input wire logic                        watchdog_timeout_i,
   input wire logic                        wake_irq_i,
   input wire logic                        global_irq_enable_i,
   // Core control
   input wire logic                        core_reset_o,
   input wire logic                        pc_load_o,
   input wire logic [12:0]                 pc_target_o,
   input wire logic                        bank_clear_o,
   input wire logic                        watchdog_expired_n_o,
   input wire logic                        sleep_entered_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic rc_off = 1'b0;
   always @(posedge clk_i)
      if (apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && apb_req_i.paddr == 8'h08)
         rc_off <= apb_req_i.pwdata[3:0] == 4'h7;

   property p_por_load;
      power_on_detect_i |=> pc_load_o && bank_clear_o && pc_target_o == reset_timeout_pkg::PC_RESET_ADDR;
   endproperty
   a_por_load: assert property (p_por_load)
      else $error("power-on load wrong");
   property p_por_flags;
      power_on_detect_i |=> watchdog_expired_n_o && sleep_entered_n_o;
   endproperty
   a_por_flags: assert property (p_por_flags)
      else $error("power-on flags wrong");
   property p_por_hold;
      power_on_detect_i && !rc_off |=> core_reset_o;
   endproperty
   a_por_hold: assert property (p_por_hold)
      else $error("power-on not held");
   property p_pin_hold;
      !external_reset_n_i |-> core_reset_o;
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("core runs with pin low");
   property p_bank_pc;
      bank_clear_o |-> pc_load_o && pc_target_o == reset_timeout_pkg::PC_RESET_ADDR;
   endproperty
   a_bank_pc: assert property (p_bank_pc)
      else $error("bank clear target");
   property p_wake_vec;
      pc_load_o && !bank_clear_o && $past(wake_irq_i && global_irq_enable_i && !watchdog_timeout_i)
         |-> pc_target_o == reset_timeout_pkg::PC_IRQ_VECTOR;
   endproperty
   a_wake_vec: assert property (p_wake_vec)
      else $error("wake target not vector");
   property p_wake_flags;
      pc_load_o && !bank_clear_o && $past(wake_irq_i && !watchdog_timeout_i)
         |-> watchdog_expired_n_o && !sleep_entered_n_o;
   endproperty
   a_wake_flags: assert property (p_wake_flags)
      else $error("wake flags wrong");
   property p_wdt_fell;
      $fell(watchdog_expired_n_o) |-> $past(watchdog_timeout_i);
   endproperty
   a_wdt_fell: assert property (p_wdt_fell)
      else $error("expired fell alone");
   property p_unmapped;
      apb_req_i.psel && apb_req_i.penable && !(apb_req_i.paddr inside {8'h00, 8'h04, 8'h08})
         |-> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped not refused");

   c_por: cover property (power_on_detect_i ##1 pc_load_o);
   c_wake: cover property (pc_load_o && pc_target_o == reset_timeout_pkg::PC_IRQ_VECTOR);
   c_wdt: cover property ($fell(watchdog_expired_n_o));
endmodule : reset_cause_checker

bind reset_timeout_and_cause_logic reset_cause_checker u_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
   .power_on_detect_i(power_on_detect_i), .external_reset_n_i(external_reset_n_i),
   .watchdog_timeout_i(watchdog_timeout_i), .wake_irq_i(wake_irq_i), .global_irq_enable_i(global_irq_enable_i),
   .core_reset_o(core_reset_o), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .bank_clear_o(bank_clear_o),
   .watchdog_expired_n_o(watchdog_expired_n_o), .sleep_entered_n_o(sleep_entered_n_o));

// *** testbench/reset_partner.sv ***
`timescale 1ns/1ps
module reset_partner (
   // Clock
   input  wire logic clk_i,
   // Bench command
   input  wire logic pin_low_cmd_i,
   // Far-side lines
   output      logic osc_clk_o,
   output      logic external_reset_n_o
);
   logic [1:0] div = 2'h0;
   initial osc_clk_o = 1'b0;
   // Free-running crystal, six clocks a period
   always @(posedge clk_i)
   begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2)
         osc_clk_o <= ~osc_clk_o;
   end
   // Pull-up on the pin: released reads high
   assign external_reset_n_o = ~pin_low_cmd_i;
endmodule : reset_partner

// *** testbench/reset_timeout_and_cause_logic_bench.sv ***
`timescale 1ns/1ps
module reset_timeout_and_cause_logic_bench;
   localparam int DLY = 20;
   localparam int OSC = 4;
   logic                        clk_i = 1'b0;
   logic                        rst_n_i = 1'b0;
   reset_timeout_pkg::apb_req_s req = '0;
   reset_timeout_pkg::apb_rsp_s rsp;
   logic                        por = 1'b0;
   logic                        blo = 1'b0;
   logic                        wdt = 1'b0;
   logic                        wake = 1'b0;
   logic                        slp = 1'b0;
   logic                        global_irq_enable = 1'b0;
   logic                        pin_low = 1'b0;
   logic [12:0]                 pc_cur = 13'h0000;
   logic                        osc, pin_n, core_reset, core_run, pc_load, bank_clear, wd_n, sl_n;
   logic [12:0]                 pc_target;
   logic [15:0]                 exp_pc[$];
   logic [63:0]                 exp_rd[$];
   logic [63:0]                 note;
   logic [31:0]                 seed = 32'h26a0abf1;
   int                          n_fail = 0;
   int                          checks_done = 0;
   int                          cyc = 0;

   always #12.5 clk_i = ~clk_i;

   reset_timeout_and_cause_logic #(.POWER_UP_DELAY_CYCLES(DLY), .OSC_STARTUP_CYCLES(OSC)) u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
      .power_on_detect_i(por), .supply_low_i(blo), .external_reset_n_i(pin_n), .osc_clk_i(osc),
      .watchdog_timeout_i(wdt), .wake_irq_i(wake), .global_irq_enable_i(global_irq_enable), .sleep_cmd_i(slp),
      .watchdog_clear_cmd_i(1'b0), .pc_current_i(pc_cur), .core_reset_o(core_reset), .core_run_o(core_run),
      .pc_load_o(pc_load), .pc_target_o(pc_target), .bank_clear_o(bank_clear),
      .watchdog_expired_n_o(wd_n), .sleep_entered_n_o(sl_n));

   reset_partner u_far (.clk_i(clk_i), .pin_low_cmd_i(pin_low), .osc_clk_o(osc), .external_reset_n_o(pin_n));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      if (n_fail == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk_i);
      req.penable <= 1'b1;
      do
         @(posedge clk_i);
      while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      exp_rd.push_back({m, v});
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   // Kinds: 0 power-on, 1 watchdog, 2 wake, 3 sleep
   task automatic ev(input int k);
      @(posedge clk_i);
      case (k)
         0: por <= 1'b1;
         1: wdt <= 1'b1;
         2: wake <= 1'b1;
         default: slp <= 1'b1;
      endcase
      @(posedge clk_i);
      {por, wdt, wake, slp} <= 4'h0;
   endtask : ev

   task automatic run_time(input int lo, input int hi);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (core_run !== 1'b1 && n < 300);
      chk("run delay", 32'h1, 32'(n >= lo && n <= hi));
   endtask : run_time

   ////////////////////////////////////////////////////////////////////////////////
   // Watcher pops oldest note per result
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (rst_n_i && pc_load)
      begin
         note = (exp_pc.size() > 0) ? 64'(exp_pc.pop_front()) : '1;
         chk("pc load", note[31:0], 32'({bank_clear, pc_target, wd_n, sl_n}));
      end
      if (req.psel && req.penable && rsp.pready && !req.pwrite)
      begin
         note = exp_rd.pop_front();
         chk("prdata", note[31:0], rsp.prdata & note[63:32]);
      end
      if (cyc == 6000)
      begin
         n_fail++;
         give_verdict();
      end
   end

   initial
   begin
      int lo;
      logic xt;
      logic off;
      logic [12:0] tgt;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(reset_timeout_pkg::ADDR_POWER_RESET_CAUSE, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(reset_timeout_pkg::ADDR_RESET_STATUS, 32'h0000_000F, 32'h0000_0007);
      rd(reset_timeout_pkg::ADDR_CONFIG, 32'hFFFF_FFFF, 32'h0000_0009);
      rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
      run_time(0, 200);
      // All modes, delay on and off
      for (int m = 0; m < 8; m++)
      begin
         off = m[0];
         xt = (m[2:1] != reset_timeout_pkg::OSC_RESISTOR_CAPACITOR);
         apb(1'b1, reset_timeout_pkg::ADDR_CONFIG, {28'h0, !off, off, 2'(m >> 1)});
         apb(1'b1, reset_timeout_pkg::ADDR_POWER_RESET_CAUSE, $random(seed) | 32'h3);
         exp_pc.push_back({1'b1, reset_timeout_pkg::PC_RESET_ADDR, 2'b11});
         ev(0);
         lo = (off ? 0 : DLY) + (xt ? (OSC - 1) * 6 : 0);
         run_time(lo, lo + (xt ? 12 : 0) + 4);
         rd(reset_timeout_pkg::ADDR_POWER_RESET_CAUSE, 32'hFFFF_FFFE, 32'h0000_0000);
         rd(reset_timeout_pkg::ADDR_RESET_STATUS, 32'h0000_0003, 32'h0000_0003);
      end
      apb(1'b1, reset_timeout_pkg::ADDR_CONFIG, 32'h0000_0009);
      apb(1'b1, reset_timeout_pkg::ADDR_POWER_RESET_CAUSE, 32'h0000_0003);
      exp_pc.push_back({1'b1, reset_timeout_pkg::PC_RESET_ADDR, 2'b11});
      @(posedge clk_i) blo <= 1'b1;
      @(posedge clk_i) blo <= 1'b0;
      run_time(DLY + (OSC - 1) * 6, DLY + OSC * 6 + 8);
      rd(reset_timeout_pkg::ADDR_POWER_RESET_CAUSE, 32'h0000_0003, 32'h0000_0002);
      exp_pc.push_back({1'b1, reset_timeout_pkg::PC_RESET_ADDR, 2'b01});
      ev(1);
      run_time(1, 4);
      // Pin held past all delays
      exp_pc.push_back({1'b1, reset_timeout_pkg::PC_RESET_ADDR, 2'b01});
      @(posedge clk_i) pin_low <= 1'b1;
      repeat (60) @(posedge clk_i);
      chk("core held", 32'h1, 32'(core_reset));
      @(posedge clk_i) pin_low <= 1'b0;
      run_time(1, 3);
      rd(reset_timeout_pkg::ADDR_POWER_RESET_CAUSE, 32'h0000_0003, 32'h0000_0002);
      // Sleep exits: vector, plain, watchdog, pin
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk_i);
         pc_cur <= 13'($random(seed));
         global_irq_enable <= (k == 0);
         ev(3);
         repeat (2) @(posedge clk_i);
         tgt = (k == 0) ? reset_timeout_pkg::PC_IRQ_VECTOR : pc_cur + 13'h1;
         tgt = (k == 3) ? reset_timeout_pkg::PC_RESET_ADDR : tgt;
         exp_pc.push_back({k == 3, tgt, k != 2, 1'b0});
         if (k == 3)
         begin
            @(posedge clk_i) pin_low <= 1'b1;
            repeat (3) @(posedge clk_i);
            pin_low <= 1'b0;
         end
         else
            ev((k == 2) ? 1 : 2);
         run_time(1, 40);
      end
      repeat (4) @(posedge clk_i);
      chk("notes left", 32'h0, 32'(exp_pc.size()));
      give_verdict();
   end
endmodule : reset_timeout_and_cause_logic_bench
